// ### hw/msst_settings_store.sv
// Persistent settings store and working configuration of a four-axis pulse controller
`timescale 1ns/10ps
// Contract
// - Start-up selects profile by index 1..4; default 1.
// - Four profiles: min, max speed, ramp 1..1000 ms.
// - Selected profile drives joystick and program moves.
// - Active-high idles outputs low, active-low high; default high.
// - Host link USB serial or Ethernet; USB default.
// - Serial rate one of seven; default 38400.
// - Axis units pulses, microns or degrees; microns default.
// - Axis divide from listed set; default 20.
// - Travel per pulse 1..1000000 in 0.1 nm steps.
// - Degree units count in micro-degrees.
// - Axis direction maps positive travel; positive default.
// - Origin off or methods one to six; default one.
// - Origin offset only for methods one, five, six.
// - Zero origin offset means half a millimetre.
// - Axis keeps or drops excitation on stop; keep default.
// - One of five drive types; stepper default.
// - Methods five, six use encoder index pulse.
module msst_settings_store import msst_pkg::*; #(
   parameter int NUM_AXES = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Selected speed profile
   output logic [2:0] activeProfileIdx,
   output logic [29:0] profMinSpeed,
   output logic [29:0] profMaxSpeed,
   output logic [9:0] profRampMs,
   // General outputs
   input wire logic [3:0] ioActive,
   output logic [3:0] ioOut,
   // Host link
   input wire logic hostTx,
   output logic hostRx,
   input wire logic usbRx,
   output logic usbTx,
   input wire logic ethRx,
   output logic ethTx,
   output logic ethSelected,
   output logic baudTick,
   // Axis control
   input wire logic [NUM_AXES-1:0] axisDirReq,
   input wire logic estopPin,
   input wire logic [NUM_AXES-1:0] encoderIndexPulse,
   input wire logic [NUM_AXES-1:0] originSensor,
   output logic [NUM_AXES-1:0] driveDir,
   output logic [NUM_AXES-1:0] motorExcite,
   output logic [NUM_AXES-1:0] originRef,
   // Axis settings in force
   output logic [NUM_AXES-1:0][1:0] axisUnit,
   output logic [NUM_AXES-1:0] axisDegreeUnits,
   output logic [NUM_AXES-1:0][7:0] axisDivide,
   output logic [NUM_AXES-1:0][19:0] axisTravelPerPulse,
   output logic [NUM_AXES-1:0][2:0] axisOriginMethod,
   output logic [NUM_AXES-1:0][29:0] axisOriginShift,
   output logic [NUM_AXES-1:0][2:0] axisDriveType
);
   typedef enum logic [1:0] {ST_LOAD = 2'b00, ST_RUN = 2'b01} msst_state_e;

   function automatic logic [31:0] defaultOf(input logic [5:0] idx);
      logic [5:0] rel;
      rel = 6'h0;
      defaultOf = 32'h0;
      if (idx == IDX_SPD_IDX) begin
         defaultOf = DEF_SPD_IDX;
      end else if (idx == IDX_POLARITY) begin
         defaultOf = DEF_POLARITY;
      end else if (idx == IDX_LINK) begin
         defaultOf = DEF_LINK;
      end else if (idx == IDX_BAUD) begin
         defaultOf = DEF_BAUD;
      end else if (idx >= IDX_PROF0 && idx < IDX_AXIS0) begin
         rel = idx - IDX_PROF0;
         case (rel[1:0])
            FLD_MIN: defaultOf = DEF_MIN[rel[3:2]];
            FLD_MAX: defaultOf = DEF_MAX[rel[3:2]];
            FLD_RAMP: defaultOf = DEF_RAMP;
            default: defaultOf = 32'h0;
         endcase
      end else if (idx >= IDX_AXIS0 && idx < IDX_END) begin
         rel = idx - IDX_AXIS0;
         case (rel[2:0])
            FLD_UNIT: defaultOf = DEF_UNIT;
            FLD_DIVIDE: defaultOf = DEF_DIVIDE;
            FLD_TPP: defaultOf = DEF_TPP;
            FLD_DIR: defaultOf = DEF_DIR;
            FLD_METHOD: defaultOf = DEF_METHOD;
            FLD_SHIFT: defaultOf = DEF_SHIFT;
            FLD_ESTOP: defaultOf = DEF_ESTOP;
            default: defaultOf = DEF_DRIVER;
         endcase
      end
   endfunction : defaultOf

   function automatic logic divideOk(input logic [31:0] v);
      case (v)
         32'd1, 32'd2, 32'd4, 32'd5, 32'd8, 32'd10, 32'd20, 32'd25, 32'd40, 32'd50, 32'd80,
         32'd100, 32'd125, 32'd200, 32'd250: divideOk = 1'b1;
         default: divideOk = 1'b0;
      endcase
   endfunction : divideOk

   function automatic logic cfgValid(input logic [5:0] idx, input logic [31:0] v);
      logic [5:0] rel;
      rel = 6'h0;
      cfgValid = 1'b0;
      if (idx == IDX_SPD_IDX) begin
         cfgValid = (v >= 32'h1) && (v <= 32'h4);
      end else if (idx == IDX_POLARITY || idx == IDX_LINK) begin
         cfgValid = (v <= 32'h1);
      end else if (idx == IDX_BAUD) begin
         cfgValid = (v <= 32'h6);
      end else if (idx >= IDX_PROF0 && idx < IDX_AXIS0) begin
         rel = idx - IDX_PROF0;
         case (rel[1:0])
            FLD_MIN, FLD_MAX: cfgValid = (v >= 32'h1) && (v <= SPEED_MAX);
            FLD_RAMP: cfgValid = (v >= 32'h1) && (v <= RAMP_MAX);
            default: cfgValid = 1'b0;
         endcase
      end else if (idx >= IDX_AXIS0 && idx < IDX_END) begin
         rel = idx - IDX_AXIS0;
         case (rel[2:0])
            FLD_UNIT: cfgValid = (v <= 32'h2);
            FLD_DIVIDE: cfgValid = divideOk(v);
            FLD_TPP: cfgValid = (v >= 32'h1) && (v <= TPP_MAX);
            FLD_DIR, FLD_ESTOP: cfgValid = (v <= 32'h1);
            FLD_METHOD: cfgValid = (v <= 32'h6);
            FLD_SHIFT: cfgValid = (v <= SHIFT_MAX);
            default: cfgValid = (v <= 32'h4);
         endcase
      end
   endfunction : cfgValid

   // Store survives a reload request; only reset_n restores factory values
   logic [31:0] cfgStore [NUM_WORDS];
   logic [31:0] cfgWork [NUM_WORDS];
   msst_state_e state;
   logic [5:0] loadIdx;
   logic ack;
   logic rejectFlag;
   logic [1:0] estopSync;
   logic [NUM_AXES-1:0] idxSync1, idxSync2, orgSync1, orgSync2;
   logic [1:0] usbSync, ethSync;

   wire [5:0] wordIdx = avs_address[7:2];
   wire isCfg = (wordIdx >= IDX_SPD_IDX && wordIdx <= IDX_BAUD) ||
                (wordIdx >= IDX_PROF0 && wordIdx < IDX_END);
   wire doWrite = avs_write && ack;
   wire [31:0] byteMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire [31:0] merged = (cfgStore[wordIdx] & ~byteMask) | (avs_writedata & byteMask);
   wire cfgWriteOk = doWrite && isCfg && cfgValid(wordIdx, merged);
   wire cfgWriteBad = doWrite && isCfg && !cfgValid(wordIdx, merged);
   wire rejectClr = doWrite && wordIdx == IDX_STATUS && avs_byteenable[0] &&
                    avs_writedata[STAT_REJECT_BIT];
   wire reloadReq = doWrite && wordIdx == IDX_CTRL && avs_byteenable[0] &&
                    avs_writedata[CTRL_RELOAD_BIT];
   wire running = (state == ST_RUN);
   wire [2:0] selIdx = cfgWork[IDX_SPD_IDX][2:0];
   wire [5:0] profBase = IDX_PROF0 + {2'h0, 2'(selIdx - 3'h1), 2'h0};
   wire [31:0] statusWord = {27'h0, selIdx, running, rejectFlag};
   wire [31:0] readWord = (wordIdx == IDX_STATUS) ? statusWord :
                          isCfg ? cfgStore[wordIdx] : 32'h0;
   wire polarityLow = cfgWork[IDX_POLARITY][0];
   wire linkEth = cfgWork[IDX_LINK][0];

   // One wait state per access keeps the store read path registered
   assign avs_waitrequest = (avs_read || avs_write) && !ack;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ack <= 1'b0;
         avs_readdata <= 32'h0;
      end else begin
         ack <= (avs_read || avs_write) && !ack;
         avs_readdata <= (avs_read && !ack) ? readWord : avs_readdata;
      end
   end

   always_ff @(posedge core_clk) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
         if (!reset_n) begin
            cfgStore[i] <= defaultOf(6'(i));
         end else if (cfgWriteOk && wordIdx == 6'(i)) begin
            cfgStore[i] <= merged;
         end
      end
   end

   // Set wins over a simultaneous clear
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rejectFlag <= 1'b0;
      end else begin
         rejectFlag <= cfgWriteBad || (rejectFlag && !rejectClr);
      end
   end

   // Working copy taken word by word; a reload stands in for a power cycle
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state <= ST_LOAD;
         loadIdx <= 6'h0;
      end else begin
         case (state)
            ST_LOAD: begin
               loadIdx <= loadIdx + 6'h1;
               if (loadIdx == 6'(NUM_WORDS - 1)) begin
                  state <= ST_RUN;
               end
            end
            default: begin
               loadIdx <= 6'h0;
               if (reloadReq) begin
                  state <= ST_LOAD;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
         if (!reset_n) begin
            cfgWork[i] <= 32'h0;
         end else if (state == ST_LOAD && loadIdx == 6'(i)) begin
            cfgWork[i] <= cfgStore[i];
         end
      end
   end

   // Pin synchronisers
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         estopSync <= 2'h0;
         idxSync1 <= '0;
         idxSync2 <= '0;
         orgSync1 <= '0;
         orgSync2 <= '0;
         usbSync <= 2'h3;
         ethSync <= 2'h3;
      end else begin
         estopSync <= {estopSync[0], estopPin};
         idxSync1 <= encoderIndexPulse;
         idxSync2 <= idxSync1;
         orgSync1 <= originSensor;
         orgSync2 <= orgSync1;
         usbSync <= {usbSync[0], usbRx};
         ethSync <= {ethSync[0], ethRx};
      end
   end

   msst_baud_gen u_baud (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .enable(running && !linkEth),
      .baudSel(cfgWork[IDX_BAUD][2:0]),
      .baudTick(baudTick)
   );

   // Profile and general settings in force, held until loading completes
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         activeProfileIdx <= DEF_SPD_IDX[2:0];
         profMinSpeed <= DEF_MIN[0][29:0];
         profMaxSpeed <= DEF_MAX[0][29:0];
         profRampMs <= DEF_RAMP[9:0];
         ioOut <= 4'h0;
         hostRx <= 1'b1;
         usbTx <= 1'b1;
         ethTx <= 1'b1;
         ethSelected <= 1'b0;
      end else if (running) begin
         activeProfileIdx <= selIdx;
         profMinSpeed <= cfgWork[profBase + 6'(FLD_MIN)][29:0];
         profMaxSpeed <= cfgWork[profBase + 6'(FLD_MAX)][29:0];
         profRampMs <= cfgWork[profBase + 6'(FLD_RAMP)][9:0];
         ioOut <= ioActive ^ {4{polarityLow}};
         hostRx <= linkEth ? ethSync[1] : usbSync[1];
         usbTx <= linkEth ? 1'b1 : hostTx;
         ethTx <= linkEth ? hostTx : 1'b1;
         ethSelected <= linkEth;
      end
   end

   // Per-axis settings and their effect on the drive lines
   always_ff @(posedge core_clk) begin
      for (int a = 0; a < NUM_AXES; a++) begin
         logic [5:0] b;
         logic [2:0] m;
         b = IDX_AXIS0 + 6'(a * 8);
         m = cfgWork[b + 6'(FLD_METHOD)][2:0];
         if (!reset_n) begin
            axisUnit[a] <= DEF_UNIT[1:0];
            axisDegreeUnits[a] <= 1'b0;
            axisDivide[a] <= DEF_DIVIDE[7:0];
            axisTravelPerPulse[a] <= DEF_TPP[19:0];
            axisOriginMethod[a] <= DEF_METHOD[2:0];
            axisOriginShift[a] <= SHIFT_ZERO_SUBST;
            axisDriveType[a] <= DEF_DRIVER[2:0];
            driveDir[a] <= 1'b0;
            motorExcite[a] <= 1'b0;
            originRef[a] <= 1'b0;
         end else if (running) begin
            axisUnit[a] <= cfgWork[b + 6'(FLD_UNIT)][1:0];
            axisDegreeUnits[a] <= cfgWork[b + 6'(FLD_UNIT)][1:0] == UNIT_DEGREE;
            axisDivide[a] <= cfgWork[b + 6'(FLD_DIVIDE)][7:0];
            axisTravelPerPulse[a] <= cfgWork[b + 6'(FLD_TPP)][19:0];
            axisOriginMethod[a] <= m;
            if (m == ORIGIN_METHOD_ONE || m == ORIGIN_METHOD_FIVE || m == ORIGIN_METHOD_SIX) begin
               axisOriginShift[a] <= (cfgWork[b + 6'(FLD_SHIFT)] == 32'h0) ? SHIFT_ZERO_SUBST :
                                     cfgWork[b + 6'(FLD_SHIFT)][29:0];
            end else begin
               axisOriginShift[a] <= 30'h0;
            end
            axisDriveType[a] <= cfgWork[b + 6'(FLD_DRIVER)][2:0];
            driveDir[a] <= axisDirReq[a] ^ cfgWork[b + 6'(FLD_DIR)][0];
            motorExcite[a] <= !estopSync[1] || cfgWork[b + 6'(FLD_ESTOP)][0];
            originRef[a] <= (m == ORIGIN_METHOD_FIVE || m == ORIGIN_METHOD_SIX) ? idxSync2[a] :
                            orgSync2[a];
         end
      end
   end
endmodule : msst_settings_store

// ### hw/msst_pkg.sv
// Constants, encodings and a serial rate helper function for the axis settings store
package msst_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int NUM_WORDS = 64;
   localparam logic [5:0] IDX_CTRL = 6'h00;
   localparam logic [5:0] IDX_STATUS = 6'h01;
   localparam logic [5:0] IDX_SPD_IDX = 6'h02;
   localparam logic [5:0] IDX_POLARITY = 6'h03;
   localparam logic [5:0] IDX_LINK = 6'h04;
   localparam logic [5:0] IDX_BAUD = 6'h05;
   localparam logic [5:0] IDX_PROF0 = 6'h08;
   localparam logic [5:0] IDX_AXIS0 = 6'h18;
   localparam logic [5:0] IDX_END = 6'h38;
   localparam logic [1:0] FLD_MIN = 2'h0;
   localparam logic [1:0] FLD_MAX = 2'h1;
   localparam logic [1:0] FLD_RAMP = 2'h2;
   localparam logic [2:0] FLD_UNIT = 3'h0;
   localparam logic [2:0] FLD_DIVIDE = 3'h1;
   localparam logic [2:0] FLD_TPP = 3'h2;
   localparam logic [2:0] FLD_DIR = 3'h3;
   localparam logic [2:0] FLD_METHOD = 3'h4;
   localparam logic [2:0] FLD_SHIFT = 3'h5;
   localparam logic [2:0] FLD_ESTOP = 3'h6;
   localparam logic [2:0] FLD_DRIVER = 3'h7;
   localparam int CTRL_RELOAD_BIT = 0;
   localparam int STAT_REJECT_BIT = 0;
   localparam int STAT_RUN_BIT = 1;
   localparam int STAT_IDX_LSB = 2;
   localparam logic [31:0] DEF_SPD_IDX = 32'h1;
   localparam logic [31:0] DEF_MIN [4] = '{32'd10000, 32'd30000, 32'd70000, 32'd100000};
   localparam logic [31:0] DEF_MAX [4] = '{32'd100000, 32'd300000, 32'd700000, 32'd1000000};
   localparam logic [31:0] DEF_RAMP = 32'd200;
   localparam logic [31:0] DEF_POLARITY = 32'h0;
   localparam logic [31:0] DEF_LINK = 32'h0;
   localparam logic [31:0] DEF_BAUD = 32'h3;
   localparam logic [31:0] DEF_UNIT = 32'h1;
   localparam logic [31:0] DEF_DIVIDE = 32'd20;
   localparam logic [31:0] DEF_TPP = 32'd1000;
   localparam logic [31:0] DEF_DIR = 32'h0;
   localparam logic [31:0] DEF_METHOD = 32'h1;
   localparam logic [31:0] DEF_SHIFT = 32'h0;
   localparam logic [31:0] DEF_ESTOP = 32'h1;
   localparam logic [31:0] DEF_DRIVER = 32'h0;
   localparam logic [31:0] SPEED_MAX = 32'd999999999;
   localparam logic [31:0] RAMP_MAX = 32'd1000;
   localparam logic [31:0] TPP_MAX = 32'd1000000;
   localparam logic [31:0] SHIFT_MAX = 32'd999999999;
   // Half a millimetre in 0.01 um steps
   localparam logic [29:0] SHIFT_ZERO_SUBST = 30'd50000;
   typedef enum logic [1:0] {UNIT_PULSE = 2'h0, UNIT_MICRON = 2'h1, UNIT_DEGREE = 2'h2} msst_unit_e;
   typedef enum logic [2:0] {
      ORIGIN_OFF = 3'h0, ORIGIN_METHOD_ONE = 3'h1, ORIGIN_METHOD_TWO = 3'h2, ORIGIN_METHOD_THREE = 3'h3,
      ORIGIN_METHOD_FOUR = 3'h4, ORIGIN_METHOD_FIVE = 3'h5, ORIGIN_METHOD_SIX = 3'h6
   } msst_origin_e;
   typedef enum logic [2:0] {
      DRV_STEPPER = 3'h0, DRV_CLOSED_LOOP = 3'h1, DRV_ROTARY_SERVO = 3'h2, DRV_LINEAR_SERVO = 3'h3,
      DRV_ALT_STEPPER = 3'h4
   } msst_drive_e;

   function automatic int baudRate(input logic [2:0] code);
      case (code)
         3'h0: baudRate = 4800;
         3'h1: baudRate = 9600;
         3'h2: baudRate = 19200;
         3'h3: baudRate = 38400;
         3'h4: baudRate = 57600;
         3'h5: baudRate = 128000;
         default: baudRate = 230400;
      endcase
   endfunction : baudRate
endpackage : msst_pkg

// ### hw/msst_baud_gen.sv
// Bit-rate enable pulse generator for the serial host path
`timescale 1ns/10ps
module msst_baud_gen import msst_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Control
   input wire logic enable,
   input wire logic [2:0] baudSel,
   // One-cycle bit-rate pulse
   output logic baudTick
);
   logic [14:0] count;
   logic [14:0] limit;
   logic wrap;

   // Integer divide; the fastest rate is off by under half a percent
   assign limit = 15'(CLK_HZ / baudRate(baudSel) - 1);
   assign wrap = (count >= limit);

   always_ff @(posedge core_clk) begin
      if (!reset_n || !enable) begin
         count <= 15'h0;
         baudTick <= 1'b0;
      end else begin
         count <= wrap ? 15'h0 : count + 15'h1;
         baudTick <= wrap;
      end
   end
endmodule : msst_baud_gen

// ### bench/msst_drive_model.sv
// Drive-side model: encoder index pulses and an origin sensor zone per axis
`timescale 1ns/10ps
module msst_drive_model #(
   parameter int NUM_AXES = 4,
   parameter int REV = 40
) (
   // Clock and commands
   input logic core_clk,
   input logic [NUM_AXES-1:0] motorExcite,
   // Feedback
   output logic [NUM_AXES-1:0] encoderIndexPulse,
   output logic [NUM_AXES-1:0] originSensor
);
   // An unexcited axis does not turn, so gives no index
   int pos [NUM_AXES] = '{default: 0};
   always @(posedge core_clk) begin
      for (int i = 0; i < NUM_AXES; i++) begin
         if (motorExcite[i] === 1'b1) begin
            pos[i] = (pos[i] + i + 1) % REV;
         end
         encoderIndexPulse[i] <= motorExcite[i] === 1'b1 && pos[i] < i + 1;
         // Sensor zone half a turn from the index
         originSensor[i] <= pos[i] >= REV / 2;
      end
   end
endmodule : msst_drive_model

// ### bench/msst_settings_store_checker.sv
// Port-level assertions for the axis settings store
`timescale 1ns/10ps
module msst_settings_store_checker import msst_pkg::*; #(
   parameter int NUM_AXES = 4
) (
   // Clock, reset and bus
   input logic core_clk,
   input logic reset_n,
   input logic [7:0] avs_address,
   input logic avs_read,
   input logic avs_write,
   input logic [31:0] avs_writedata,
   input logic avs_waitrequest,
   // Profile and link
   input logic [2:0] activeProfileIdx,
   input logic [29:0] profMinSpeed,
   input logic [9:0] profRampMs,
   input logic [3:0] ioActive,
   input logic [3:0] ioOut,
   input logic ethSelected,
   input logic baudTick,
   // Axes
   input logic [NUM_AXES-1:0] axisDirReq,
   input logic estopPin,
   input logic [NUM_AXES-1:0] encoderIndexPulse,
   input logic [NUM_AXES-1:0] originSensor,
   input logic [NUM_AXES-1:0] driveDir,
   input logic [NUM_AXES-1:0] motorExcite,
   input logic [NUM_AXES-1:0] originRef,
   input logic [NUM_AXES-1:0][2:0] axisOriginMethod,
   input logic [NUM_AXES-1:0][29:0] axisOriginShift
);
   // Settle window; outputs freeze while the working copy loads
   logic [6:0] quiet;
   wire reloadHit = avs_write && !avs_waitrequest && avs_address[7:2] == 6'h0 && avs_writedata[0];
   wire ready = &quiet;
   always_ff @(posedge core_clk) begin
      if (!reset_n || reloadHit) begin
         quiet <= 7'h0;
      end else if (!ready) begin
         quiet <= quiet + 7'h1;
      end
   end
   function automatic logic shiftOk(input logic [NUM_AXES-1:0][2:0] m, input logic [NUM_AXES-1:0][29:0] s);
      shiftOk = 1'b1;
      for (int i = 0; i < NUM_AXES; i++) begin
         if ((m[i] inside {3'h1, 3'h5, 3'h6}) == (s[i] == 30'h0)) shiftOk = 1'b0;
      end
   endfunction : shiftOk
   function automatic logic refOk(input logic [NUM_AXES-1:0][2:0] m, input logic [NUM_AXES-1:0] e, o, r);
      refOk = 1'b1;
      for (int i = 0; i < NUM_AXES; i++) begin
         if (r[i] != ((m[i] inside {3'h5, 3'h6}) ? e[i] : o[i])) refOk = 1'b0;
      end
   endfunction : refOk
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence busPending;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence busAnswered;
      !avs_waitrequest;
   endsequence
   AST_BUS_ONE_WAIT: assert property (busPending |=> busAnswered)
      else $error("bus wait");
   AST_PROFILE_IDX: assert property (activeProfileIdx inside {[3'h1:3'h4]})
      else $error("profile index");
   AST_PROFILE_VALS: assert property (profRampMs inside {[10'h1:10'h3e8]} && profMinSpeed != 30'h0)
      else $error("profile values");
   AST_IO_POLARITY: assert property (ready |-> (ioOut ^ $past(ioActive)) inside {4'h0, 4'hf})
      else $error("output polarity");
   AST_DIR_FOLLOW: assert property (ready |-> (driveDir ^ $past(driveDir)) == ($past(axisDirReq) ^ $past(axisDirReq, 2)))
      else $error("direction");
   AST_LINK_QUIET: assert property (ethSelected |-> !baudTick)
      else $error("rate pulse on network");
   AST_SHIFT_GATE: assert property (shiftOk(axisOriginMethod, axisOriginShift))
      else $error("origin shift");
   AST_ORIGIN_REF: assert property (ready |-> refOk(axisOriginMethod, $past(encoderIndexPulse, 3), $past(originSensor, 3), originRef))
      else $error("origin reference");
   AST_ESTOP_KEEP: assert property (ready && !$past(estopPin, 3) |-> &motorExcite)
      else $error("excitation dropped");
endmodule : msst_settings_store_checker
bind msst_settings_store msst_settings_store_checker #(.NUM_AXES(NUM_AXES)) chk (.*);

// ### bench/msst_settings_store_tb.sv
// Self-checking bench for the axis settings store
`timescale 1ns/10ps
module msst_settings_store_tb import msst_pkg::*;;
   localparam int NA = 4;
   localparam logic [31:0] AX_DEF [8] = '{DEF_UNIT, DEF_DIVIDE, DEF_TPP, DEF_DIR, DEF_METHOD, DEF_SHIFT, DEF_ESTOP,
      DEF_DRIVER};
   localparam int DIVS [15] = '{1, 2, 4, 5, 8, 10, 20, 25, 40, 50, 80, 100, 125, 200, 250};
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] avs_address = 8'h0;
   logic avs_read = 1'b0, avs_write = 1'b0, estopPin = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [3:0] ioActive = 4'h0;
   logic hostTx = 1'b1, usbRx = 1'b1, ethRx = 1'b1;
   logic [NA-1:0] axisDirReq = '0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, hostRx, usbTx, ethTx, ethSelected, baudTick;
   logic [2:0] activeProfileIdx;
   logic [29:0] profMinSpeed, profMaxSpeed;
   logic [9:0] profRampMs;
   logic [3:0] ioOut;
   logic [NA-1:0] encoderIndexPulse, originSensor, driveDir, motorExcite, originRef, axisDegreeUnits;
   logic [NA-1:0][1:0] axisUnit;
   logic [NA-1:0][7:0] axisDivide;
   logic [NA-1:0][19:0] axisTravelPerPulse;
   logic [NA-1:0][2:0] axisOriginMethod, axisDriveType;
   logic [NA-1:0][29:0] axisOriginShift;
   logic [31:0] rdQ [$];
   logic [31:0] seed = 32'hf79f;
   int mismatches = 0, checksDone = 0, cycles = 0;
   msst_settings_store #(.NUM_AXES(NA)) uut (.*);
   msst_drive_model #(.NUM_AXES(NA)) drv (.core_clk, .motorExcite, .encoderIndexPulse, .originSensor);
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      hostTx <= ~hostTx;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         tallyAndFinish();
      end
   end
   // Oldest note meets each read answer while a note is queued; status polls go unchecked
   always @(posedge core_clk) begin
      if (avs_read && !avs_waitrequest && rdQ.size() > 0) begin
         check(avs_readdata, rdQ.pop_front());
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic busWr(input logic [7:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      @(posedge core_clk);
      while (avs_waitrequest) @(posedge core_clk);
      avs_write <= 1'b0;
      @(posedge core_clk);
   endtask : busWr
   task automatic busRd(input logic [7:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      @(posedge core_clk);
      while (avs_waitrequest) @(posedge core_clk);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask : busRd
   task automatic expRd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rdQ.push_back(e);
      busRd(a, d);
   endtask : expRd
   task automatic waitLoad();
      logic [31:0] d;
      d = 32'h0;
      repeat (3) @(posedge core_clk);
      while (d[1] !== 1'b1) busRd(8'h04, d);
      repeat (4) @(posedge core_clk);
   endtask : waitLoad
   task automatic reload();
      busWr(8'h00, 32'h1);
      waitLoad();
   endtask : reload
   task automatic tallyAndFinish();
      $display("checks %0d mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tallyAndFinish
   initial begin
      logic [31:0] mn, mx, sh;
      int n;
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      waitLoad();
      check(32'(activeProfileIdx), 32'h1);
      check(32'(profMinSpeed), DEF_MIN[0]);
      check(32'(profMaxSpeed), DEF_MAX[0]);
      check(32'(axisOriginShift[1]), 32'd50000);
      check(32'(ethTx), 32'h1);
      expRd(8'h08, 32'h1);
      expRd(8'h0c, 32'h0);
      expRd(8'h10, 32'h0);
      expRd(8'h14, 32'h3);
      for (int p = 0; p < 4; p++) begin
         expRd(8'h20 + 8'(16 * p), DEF_MIN[p]);
         expRd(8'h24 + 8'(16 * p), DEF_MAX[p]);
         expRd(8'h28 + 8'(16 * p), 32'd200);
         expRd(8'h2c + 8'(16 * p), 32'h0);
      end
      for (int a = 0; a < NA; a++) begin
         for (int f = 0; f < 8; f++) begin
            expRd(8'h60 + 8'(32 * a + 4 * f), AX_DEF[f]);
         end
      end
      $display("test defaults done");
      mn = rnd() % 32'd500000 + 32'h1;
      mx = mn + rnd() % 32'd1000000 + 32'h1;
      busWr(8'h50, mn);
      busWr(8'h54, mx);
      busWr(8'h58, 32'd1000);
      avs_byteenable <= 4'h1;
      busWr(8'h28, 32'hffffff64);
      avs_byteenable <= 4'hf;
      expRd(8'h28, 32'h64);
      busWr(8'h08, 32'h4);
      check(32'(activeProfileIdx), 32'h1);
      busWr(8'h58, 32'd1001);
      expRd(8'h58, 32'd1000);
      expRd(8'h04, 32'h7);
      busWr(8'h04, 32'h1);
      busWr(8'h08, 32'h5);
      expRd(8'h08, 32'h4);
      busWr(8'h04, 32'h1);
      reload();
      check(32'(activeProfileIdx), 32'h4);
      check(32'(profMinSpeed), mn);
      check(32'(profMaxSpeed), mx);
      check(32'(profRampMs), 32'd1000);
      expRd(8'h04, 32'h12);
      $display("test profile done");
      for (int c = 0; c < 7; c++) begin
         busWr(8'h14, 32'(c));
         expRd(8'h14, 32'(c));
      end
      busWr(8'h14, 32'h7);
      expRd(8'h14, 32'h6);
      reload();
      for (n = 0; baudTick !== 1'b1 && n < 1000; n++) @(posedge core_clk);
      @(posedge core_clk);
      for (n = 1; baudTick !== 1'b1 && n < 1000; n++) @(posedge core_clk);
      check(32'(n inside {[CLK_HZ / 230400 - 1:CLK_HZ / 230400 + 1]}), 32'h1);
      $display("test serial rate done");
      busWr(8'h0c, 32'h1);
      busWr(8'h10, 32'h1);
      busWr(8'h60, 32'h2);
      busWr(8'h68, 32'd1000000);
      busWr(8'h68, 32'd1000001);
      expRd(8'h68, 32'd1000000);
      busWr(8'h8c, 32'h1);
      busWr(8'hd8, 32'h0);
      foreach (DIVS[i]) begin
         busWr(8'h84, 32'(DIVS[i]));
         expRd(8'h84, 32'(DIVS[i]));
      end
      busWr(8'h84, 32'h3);
      expRd(8'h84, 32'd250);
      axisDirReq <= 4'h3;
      ioActive <= 4'h5;
      estopPin <= 1'b1;
      usbRx <= 1'b0;
      reload();
      check(32'(ioOut), 32'ha);
      check(32'(driveDir), 32'h1);
      check(32'(motorExcite), 32'h7);
      check(32'(axisUnit[0]), 32'h2);
      check(32'(axisDegreeUnits), 32'h1);
      check(32'(axisDivide[1]), 32'd250);
      check(32'(axisTravelPerPulse[0]), 32'd1000000);
      check(32'(ethSelected), 32'h1);
      check(32'({usbTx, hostRx}), 32'h3);
      $display("test axis settings done");
      sh = rnd() % 32'd999999999 + 32'h1;
      for (int m = 0; m < 7; m++) begin
         busWr(8'hb0, 32'(m));
         busWr(8'hb4, m[0] ? 32'h0 : sh);
         busWr(8'hdc, 32'(m % 5));
         reload();
         check(32'(axisOriginMethod[2]), 32'(m));
         check(32'(axisOriginShift[2]), !(m inside {1, 5, 6}) ? 32'h0 : m[0] ? 32'd50000 : sh);
         check(32'(axisDriveType[3]), 32'(m % 5));
      end
      busWr(8'hb0, 32'h7);
      expRd(8'hb0, 32'h6);
      $display("test origin and drive done");
      tallyAndFinish();
   end
endmodule : msst_settings_store_tb
